// ==== core/ddcc_consts.svh ====
// Offsets, field positions, reset values and timing counts of the configuration slice
`ifndef DDCC_CONSTS_SVH
`define DDCC_CONSTS_SVH

`define DDCC_ADDR_W 13
`define DDCC_OFS_QCLK_CTRL 13'h120
`define DDCC_OFS_TRIM_SEL 13'h121
`define DDCC_OFS_RSVD_KEEP 13'h12A
`define DDCC_OFS_CH0_GAIN 13'h130
`define DDCC_OFS_CH0_STEP_LO 13'h131
`define DDCC_OFS_CH0_STEP_HI 13'h132
`define DDCC_OFS_CH1_GAIN 13'h138
`define DDCC_OFS_CH1_STEP_LO 13'h139
`define DDCC_OFS_CH1_STEP_HI 13'h13A

`define DDCC_QCLK_EN_BIT 4
`define DDCC_QCLK_TERM_BIT 3
`define DDCC_SWING_LSB 0
`define DDCC_DEC2_LSB 4
`define DDCC_DEC8_LSB 0
`define DDCC_STEP_HI_LSB 0

`define DDCC_RST_QCLK_CTRL 8'h11
`define DDCC_RST_RSVD_KEEP 8'h05
`define DDCC_RST_TRIM_FAST 2'h0
`define DDCC_RST_TRIM_SLOW 2'h3
`define DDCC_TRIM_WIDE_BAND 2'h3

`define DDCC_QCLK_HALF_TICKS 2'h2
`define DDCC_INSTR_BITS 5'h10
`define DDCC_FRAME_BITS 5'h18
`define DDCC_PHASE_W 10
`endif

// ==== core/ddcc_pkg.sv ====
// Types shared by the configuration slice
package ddcc_pkg;
  // Gain codes of the two polyphase stages of one channel
  typedef struct packed {
    logic [1:0] dec2;
    logic [1:0] dec8;
  } ddcc_gain_t;

  // Quarter-rate clock output controls
  typedef struct packed {
    logic enable;
    logic termination;
    logic [1:0] swing;
  } ddcc_qclk_t;

  // Serial port frame phase
  typedef enum logic [1:0] {
    SP_INSTR,
    SP_DATA,
    SP_DONE
  } ddcc_sp_state_t;
endpackage

// ==== core/ddcc_config.sv ====
// Configuration slice: serial port registers, quarter-rate clock, NCO steps, stage gains
`timescale 1ns/10ps
`include "ddcc_consts.svh"

// Function
// - Enabled quarter-rate clock output toggles at one quarter of sample clock.
// - Control bit 4 turns the quarter-rate clock output off (0) or on (1).
// - Control bits 1:0 select swing codes 00..11, 100 to 400 mV.
// - Trim field bits 1:0; slowest variant accepts only code 11.
// - Fastest variant trims 00 and 01 (all variants but the slowest accept all four codes); reset trim 00 fast, 11 slowest.
// - Channel 0 gain bits 5:4 set decimate-by-2 stage gain, 6 dB steps.
// - Channel 0 gain bits 1:0 set decimate-by-8 stage gain, 6 dB steps.
// - Channel 0 phase step: low byte 0x131, top two bits 0x132[1:0].
// - Mixing frequency is step times sample rate over 1024; accumulator wraps.
// - Channel 1 gain bits 5:4 set decimate-by-2 stage gain, 6 dB steps.
// - Channel 1 gain bits 1:0 set decimate-by-8 stage gain, 6 dB steps.
// - Channel 1 phase step: low byte 0x139, top two bits 0x13A[1:0].
module ddcc_config #(
  parameter int VARIANT = 2,
  parameter int SAMPLE_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial control port
  input wire logic sp_csb_n,
  input wire logic sp_sclk,
  input wire logic sp_sdi,
  output logic sp_sdo,
  output logic sp_sdo_oe,
  // Sample clock stand-in, one pulse per sample
  input wire logic sample_tick,
  // Stage samples to be scaled, decimate-by-2 then decimate-by-8 per channel
  input wire logic signed [SAMPLE_W-1:0] ch0_dec2_in,
  input wire logic signed [SAMPLE_W-1:0] ch0_dec8_in,
  input wire logic signed [SAMPLE_W-1:0] ch1_dec2_in,
  input wire logic signed [SAMPLE_W-1:0] ch1_dec8_in,
  // Scaled stage samples
  output logic signed [SAMPLE_W-1:0] ch0_dec2_out,
  output logic signed [SAMPLE_W-1:0] ch0_dec8_out,
  output logic signed [SAMPLE_W-1:0] ch1_dec2_out,
  output logic signed [SAMPLE_W-1:0] ch1_dec8_out,
  // Quarter-rate clock output and its controls
  output logic quarter_rate_clock_output,
  output ddcc_pkg::ddcc_qclk_t qclk_ctrl,
  // Trim and channel settings
  output logic [1:0] trim_code,
  output ddcc_pkg::ddcc_gain_t ch0_gain,
  output ddcc_pkg::ddcc_gain_t ch1_gain,
  output logic [`DDCC_PHASE_W-1:0] ch0_phase_step,
  output logic [`DDCC_PHASE_W-1:0] ch1_phase_step,
  output logic [`DDCC_PHASE_W-1:0] ch0_phase,
  output logic [`DDCC_PHASE_W-1:0] ch1_phase
);
  import ddcc_pkg::*;

  localparam logic [1:0] TRIM_RESET = (VARIANT == 0) ? `DDCC_RST_TRIM_SLOW : `DDCC_RST_TRIM_FAST;
  localparam int WIDE_W = SAMPLE_W + 3;
  localparam logic [7:0] QCLK_RESET = `DDCC_RST_QCLK_CTRL;

  // Saturating left shift by 0..3, one bit per 6 dB
  function automatic logic signed [SAMPLE_W-1:0] sat_shift(input logic signed [SAMPLE_W-1:0] x,
                                                          input logic [1:0] sh);
    logic signed [WIDE_W-1:0] wide;
    logic signed [WIDE_W-1:0] maxv;
    logic signed [WIDE_W-1:0] minv;
    wide = WIDE_W'(x) <<< sh;
    maxv = WIDE_W'({1'b0, {(SAMPLE_W-1){1'b1}}});
    minv = -maxv - WIDE_W'(1);
    if (wide > maxv) begin
      sat_shift = maxv[SAMPLE_W-1:0];
    end else if (wide < minv) begin
      sat_shift = minv[SAMPLE_W-1:0];
    end else begin
      sat_shift = wide[SAMPLE_W-1:0];
    end
  endfunction

  ddcc_sp_state_t sp_state_reg;
  logic sclk_q_reg;
  logic [4:0] bit_cnt_reg;
  logic [15:0] instr_reg;
  logic [7:0] data_in_reg;
  logic [7:0] data_out_reg;
  logic [7:0] rsvd_keep_reg;
  logic [1:0] qclk_cnt_reg;
  logic rise;
  logic fall;
  logic is_read;
  logic [`DDCC_ADDR_W-1:0] addr;
  logic [7:0] rd_data;
  logic wr_commit;
  logic commit_reg;

  // Edges of the port clock; inputs are taken as synchronous
  assign rise = sp_sclk & ~sclk_q_reg & ~sp_csb_n;
  assign fall = ~sp_sclk & sclk_q_reg & ~sp_csb_n;
  assign is_read = instr_reg[15];
  assign addr = instr_reg[`DDCC_ADDR_W-1:0];
  assign wr_commit = commit_reg;

  // Port clock history; commit waits one edge so the last data bit is already shifted in
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_q_reg <= 1'b0;
      commit_reg <= 1'b0;
    end else begin
      sclk_q_reg <= sp_sclk;
      commit_reg <= rise & (sp_state_reg == SP_DATA) & ~is_read & (bit_cnt_reg == `DDCC_FRAME_BITS - 5'h01);
    end
  end

  // Frame sequencing: 16-bit instruction (R/W, 2 ignored, 13-bit address), then one byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sp_state_reg <= SP_INSTR;
      bit_cnt_reg <= 5'h00;
    end else if (sp_csb_n) begin
      sp_state_reg <= SP_INSTR;
      bit_cnt_reg <= 5'h00;
    end else if (rise) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      case (sp_state_reg)
        SP_INSTR: begin
          if (bit_cnt_reg == `DDCC_INSTR_BITS - 5'h01) begin
            sp_state_reg <= SP_DATA;
          end
        end
        SP_DATA: begin
          if (bit_cnt_reg == `DDCC_FRAME_BITS - 5'h01) begin
            sp_state_reg <= SP_DONE; // Extra clocks after one byte are ignored
          end
        end
        SP_DONE: begin
          bit_cnt_reg <= bit_cnt_reg;
        end
        default: begin
          sp_state_reg <= SP_INSTR;
        end
      endcase
    end
  end

  // Shift in instruction and data, MSB first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      instr_reg <= 16'h0000;
      data_in_reg <= 8'h00;
    end else if (rise) begin
      if (sp_state_reg == SP_INSTR) begin
        instr_reg <= {instr_reg[14:0], sp_sdi};
      end else if (sp_state_reg == SP_DATA) begin
        data_in_reg <= {data_in_reg[6:0], sp_sdi};
      end
    end
  end

  // Read mux; unused bits read as zero
  always_comb begin
    rd_data = 8'h00;
    case (addr)
      `DDCC_OFS_QCLK_CTRL: rd_data = {3'h0, qclk_ctrl.enable, qclk_ctrl.termination, 1'b0, qclk_ctrl.swing};
      `DDCC_OFS_TRIM_SEL: rd_data = {6'h00, trim_code};
      `DDCC_OFS_RSVD_KEEP: rd_data = rsvd_keep_reg;
      `DDCC_OFS_CH0_GAIN: rd_data = {2'h0, ch0_gain.dec2, 2'h0, ch0_gain.dec8};
      `DDCC_OFS_CH0_STEP_LO: rd_data = ch0_phase_step[7:0];
      `DDCC_OFS_CH0_STEP_HI: rd_data = {6'h00, ch0_phase_step[9:8]};
      `DDCC_OFS_CH1_GAIN: rd_data = {2'h0, ch1_gain.dec2, 2'h0, ch1_gain.dec8};
      `DDCC_OFS_CH1_STEP_LO: rd_data = ch1_phase_step[7:0];
      `DDCC_OFS_CH1_STEP_HI: rd_data = {6'h00, ch1_phase_step[9:8]};
      default: rd_data = 8'h00;
    endcase
  end

  // Read data leaves on falling edges, so the host samples it on the next rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_out_reg <= 8'h00;
      sp_sdo <= 1'b0;
      sp_sdo_oe <= 1'b0;
    end else if (sp_csb_n) begin
      sp_sdo_oe <= 1'b0;
      sp_sdo <= 1'b0;
    end else if (fall && sp_state_reg == SP_DATA && is_read) begin
      if (bit_cnt_reg == `DDCC_INSTR_BITS) begin
        sp_sdo <= rd_data[7];
        data_out_reg <= {rd_data[6:0], 1'b0};
      end else begin
        sp_sdo <= data_out_reg[7];
        data_out_reg <= {data_out_reg[6:0], 1'b0};
      end
      sp_sdo_oe <= 1'b1;
    end else if (sp_state_reg == SP_DONE && fall) begin
      sp_sdo_oe <= 1'b0; // Release after the last bit
    end
  end

  // Quarter-rate clock controls
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      qclk_ctrl.enable <= QCLK_RESET[`DDCC_QCLK_EN_BIT];
      qclk_ctrl.termination <= QCLK_RESET[`DDCC_QCLK_TERM_BIT];
      qclk_ctrl.swing <= QCLK_RESET[`DDCC_SWING_LSB+:2];
    end else if (wr_commit && addr == `DDCC_OFS_QCLK_CTRL) begin
      qclk_ctrl.enable <= data_in_reg[`DDCC_QCLK_EN_BIT];
      qclk_ctrl.termination <= data_in_reg[`DDCC_QCLK_TERM_BIT];
      qclk_ctrl.swing <= data_in_reg[`DDCC_SWING_LSB+:2];
    end
  end

  // Trim select; the slowest variant refuses the three fast trims
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trim_code <= TRIM_RESET;
    end else if (wr_commit && addr == `DDCC_OFS_TRIM_SEL) begin
      if (VARIANT != 0 || data_in_reg[1:0] == `DDCC_TRIM_WIDE_BAND) begin
        trim_code <= data_in_reg[1:0];
      end
    end
  end

  // Reserved register; plain storage, software is expected to leave 0x05
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsvd_keep_reg <= `DDCC_RST_RSVD_KEEP;
    end else if (wr_commit && addr == `DDCC_OFS_RSVD_KEEP) begin
      rsvd_keep_reg <= data_in_reg;
    end
  end

  // Channel gain codes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ch0_gain <= '0;
      ch1_gain <= '0;
    end else if (wr_commit) begin
      if (addr == `DDCC_OFS_CH0_GAIN) begin
        ch0_gain.dec2 <= data_in_reg[`DDCC_DEC2_LSB+:2];
        ch0_gain.dec8 <= data_in_reg[`DDCC_DEC8_LSB+:2];
      end
      if (addr == `DDCC_OFS_CH1_GAIN) begin
        ch1_gain.dec2 <= data_in_reg[`DDCC_DEC2_LSB+:2];
        ch1_gain.dec8 <= data_in_reg[`DDCC_DEC8_LSB+:2];
      end
    end
  end

  // Phase steps; the two bytes take effect independently as each is written
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ch0_phase_step <= '0;
      ch1_phase_step <= '0;
    end else if (wr_commit) begin
      case (addr)
        `DDCC_OFS_CH0_STEP_LO: ch0_phase_step[7:0] <= data_in_reg;
        `DDCC_OFS_CH0_STEP_HI: ch0_phase_step[9:8] <= data_in_reg[`DDCC_STEP_HI_LSB+:2];
        `DDCC_OFS_CH1_STEP_LO: ch1_phase_step[7:0] <= data_in_reg;
        `DDCC_OFS_CH1_STEP_HI: ch1_phase_step[9:8] <= data_in_reg[`DDCC_STEP_HI_LSB+:2];
        default: ch0_phase_step <= ch0_phase_step;
      endcase
    end
  end

  // Phase accumulators wrap modulo 1024 by their own width
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ch0_phase <= '0;
      ch1_phase <= '0;
    end else if (sample_tick) begin
      ch0_phase <= ch0_phase + ch0_phase_step;
      ch1_phase <= ch1_phase + ch1_phase_step;
    end
  end

  // Quarter-rate clock: toggle every second sample; held low while disabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      qclk_cnt_reg <= 2'h0;
      quarter_rate_clock_output <= 1'b0;
    end else if (!qclk_ctrl.enable) begin
      qclk_cnt_reg <= 2'h0;
      quarter_rate_clock_output <= 1'b0;
    end else if (sample_tick) begin
      if (qclk_cnt_reg == `DDCC_QCLK_HALF_TICKS - 2'h1) begin
        qclk_cnt_reg <= 2'h0;
        quarter_rate_clock_output <= ~quarter_rate_clock_output;
      end else begin
        qclk_cnt_reg <= qclk_cnt_reg + 2'h1;
      end
    end
  end

  // Stage scaling, one cycle of latency
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ch0_dec2_out <= '0;
      ch0_dec8_out <= '0;
      ch1_dec2_out <= '0;
      ch1_dec8_out <= '0;
    end else begin
      ch0_dec2_out <= sat_shift(ch0_dec2_in, ch0_gain.dec2);
      ch0_dec8_out <= sat_shift(ch0_dec8_in, ch0_gain.dec8);
      ch1_dec2_out <= sat_shift(ch1_dec2_in, ch1_gain.dec2);
      ch1_dec8_out <= sat_shift(ch1_dec8_in, ch1_gain.dec8);
    end
  end
endmodule

// ==== bench/ddcc_host.sv ====
// Host model: drives serial port frames and captures read bytes
`timescale 1ns/10ps
module ddcc_host (
  // Clock
  input wire logic clk,
  // Serial port
  output logic csb_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    csb_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  // One byte per frame; nb below 24 aborts the frame early
  task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] d, input int nb, output logic [7:0] q);
    logic [23:0] f;
    f = {rd, 2'h0, a, d};
    q = 8'h00;
    if (!rd && a == 13'h12A) f[7:0] = 8'h05;
    @(negedge clk) csb_n = 1'b0;
    for (int i = 23; i >= 24 - nb; i--) begin
      sdi = f[i];
      repeat (2) @(negedge clk);
      if (i < 8) q[i] = sdo;
      sclk = 1'b1;
      repeat (2) @(negedge clk);
      sclk = 1'b0;
    end
    // Hold select past the commit edge, then release data line inverted
    repeat (3) @(negedge clk);
    csb_n = 1'b1;
    sdi = ~sdi;
    repeat (2) @(negedge clk);
  endtask
endmodule

// ==== bench/ddcc_config_chk.sv ====
// Checker for the configuration slice outputs
`timescale 1ns/10ps
`include "ddcc_consts.svh"
module ddcc_config_chk #(
  parameter int VARIANT = 2,
  parameter int SAMPLE_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Activity
  input wire logic sp_csb_n,
  input wire logic sample_tick,
  // Stage samples
  input wire logic signed [SAMPLE_W-1:0] ch0_dec2_in,
  input wire logic signed [SAMPLE_W-1:0] ch1_dec8_in,
  input wire logic signed [SAMPLE_W-1:0] ch0_dec2_out,
  input wire logic signed [SAMPLE_W-1:0] ch1_dec8_out,
  // Settings
  input wire logic quarter_rate_clock_output,
  input ddcc_pkg::ddcc_qclk_t qclk_ctrl,
  input wire logic [1:0] trim_code,
  input ddcc_pkg::ddcc_gain_t ch0_gain,
  input ddcc_pkg::ddcc_gain_t ch1_gain,
  input wire logic [`DDCC_PHASE_W-1:0] ch0_phase_step,
  input wire logic [`DDCC_PHASE_W-1:0] ch1_phase_step,
  input wire logic [`DDCC_PHASE_W-1:0] ch0_phase,
  input wire logic [`DDCC_PHASE_W-1:0] ch1_phase
);
  import ddcc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Saturating shift, wide enough that three steps never wrap
  function automatic logic signed [SAMPLE_W-1:0] sat(input logic signed [SAMPLE_W-1:0] x, input logic [1:0] s);
    logic signed [SAMPLE_W+3:0] w;
    logic signed [SAMPLE_W+3:0] hi;
    w = (SAMPLE_W+4)'(x) <<< s;
    hi = (SAMPLE_W+4)'(2 ** (SAMPLE_W - 1) - 1);
    if (w > hi) begin
      w = hi;
    end else if (w < -hi - (SAMPLE_W+4)'(1)) begin
      w = -hi - (SAMPLE_W+4)'(1);
    end
    return w[SAMPLE_W-1:0];
  endfunction

  sequence s_port_idle; sp_csb_n [*3]; endsequence
  sequence s_clk_off; !qclk_ctrl.enable [*2]; endsequence

  property p_phase_acc; sample_tick |=> ch0_phase == $past(ch0_phase) + $past(ch0_phase_step); endproperty
  a_phase_acc: assert property (p_phase_acc) else $error("phase 0 did not advance by its step");
  property p_phase_hold; !sample_tick |=> $stable(ch1_phase); endproperty
  a_phase_hold: assert property (p_phase_hold) else $error("phase 1 moved without a tick");
  property p_qclk_off; s_clk_off |-> !quarter_rate_clock_output; endproperty
  a_qclk_off: assert property (p_qclk_off) else $error("quarter clock active while off");
  property p_qclk_tick; qclk_ctrl.enable && $changed(quarter_rate_clock_output) |-> $past(sample_tick); endproperty
  a_qclk_tick: assert property (p_qclk_tick) else $error("quarter clock moved without a tick");
  property p_gain0; 1 |=> ch0_dec2_out == sat($past(ch0_dec2_in), $past(ch0_gain.dec2)); endproperty
  a_gain0: assert property (p_gain0) else $error("channel 0 stage gain wrong");
  property p_gain1; 1 |=> ch1_dec8_out == sat($past(ch1_dec8_in), $past(ch1_gain.dec8)); endproperty
  a_gain1: assert property (p_gain1) else $error("channel 1 stage gain wrong");
  property p_cfg_stable; s_port_idle |-> $stable(trim_code) && $stable(ch1_phase_step); endproperty
  a_cfg_stable: assert property (p_cfg_stable) else $error("setting changed with port idle");
  property p_trim_legal; VARIANT != 0 || trim_code == 2'h3; endproperty
  a_trim_legal: assert property (p_trim_legal) else $error("illegal trim on slowest variant");
endmodule

bind ddcc_config ddcc_config_chk #(.VARIANT(VARIANT), .SAMPLE_W(SAMPLE_W)) u_chk (.clk, .rst, .sp_csb_n,
  .sample_tick, .ch0_dec2_in, .ch1_dec8_in, .ch0_dec2_out, .ch1_dec8_out, .quarter_rate_clock_output,
  .qclk_ctrl, .trim_code, .ch0_gain, .ch1_gain, .ch0_phase_step, .ch1_phase_step, .ch0_phase, .ch1_phase);

// ==== bench/tb.sv ====
// Self-checking bench for the configuration slice
`timescale 1ns/10ps
module tb;
  import ddcc_pkg::*;
  logic clk, rst, csb_n, sclk, sdi, sdo, sdo_oe, tick, qout;
  logic signed [15:0] din [4];
  logic signed [15:0] dout [4];
  ddcc_qclk_t qctl;
  ddcc_gain_t g0, g1;
  logic [1:0] trim, trim_s;
  logic [9:0] st0, st1, ph0, ph1, p0, p1;
  logic [7:0] m [logic [12:0]];
  logic [12:0] regs [10] = '{13'h120, 13'h121, 13'h12A, 13'h130, 13'h131, 13'h132, 13'h138, 13'h139, 13'h13A, 13'h122};
  logic [31:0] lfsr = 32'h462B;
  logic [7:0] q;
  int mismatches = 0, n_checks = 0, tog;

  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ddcc_host host (.clk, .csb_n, .sclk, .sdi, .sdo);
  ddcc_config dut (.clk, .rst, .sp_csb_n(csb_n), .sp_sclk(sclk), .sp_sdi(sdi), .sp_sdo(sdo), .sp_sdo_oe(sdo_oe),
    .sample_tick(tick), .ch0_dec2_in(din[0]), .ch0_dec8_in(din[1]), .ch1_dec2_in(din[2]), .ch1_dec8_in(din[3]),
    .ch0_dec2_out(dout[0]), .ch0_dec8_out(dout[1]), .ch1_dec2_out(dout[2]), .ch1_dec8_out(dout[3]),
    .quarter_rate_clock_output(qout), .qclk_ctrl(qctl), .trim_code(trim), .ch0_gain(g0), .ch1_gain(g1),
    .ch0_phase_step(st0), .ch1_phase_step(st1), .ch0_phase(ph0), .ch1_phase(ph1));
  // Slowest variant on the same port, so its trim refusals are exercised
  ddcc_config #(.VARIANT(0)) dut_slow (.clk, .rst, .sp_csb_n(csb_n), .sp_sclk(sclk), .sp_sdi(sdi), .sp_sdo(),
    .sp_sdo_oe(), .sample_tick(tick), .ch0_dec2_in(din[0]), .ch0_dec8_in(din[1]), .ch1_dec2_in(din[2]),
    .ch1_dec8_in(din[3]), .ch0_dec2_out(), .ch0_dec8_out(), .ch1_dec2_out(), .ch1_dec8_out(),
    .quarter_rate_clock_output(), .qclk_ctrl(), .trim_code(trim_s), .ch0_gain(), .ch1_gain(),
    .ch0_phase_step(), .ch1_phase_step(), .ch0_phase(), .ch1_phase());

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  // Writable bits per address; zero marks an unmapped place
  function automatic logic [7:0] msk(input logic [12:0] a);
    case (a)
      13'h120: return 8'h1B;
      13'h121, 13'h132, 13'h13A: return 8'h03;
      13'h130, 13'h138: return 8'h33;
      13'h12A, 13'h131, 13'h139: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, 24, q);
    if (msk(a) != 8'h00) m[a] = (a == 13'h12A) ? 8'h05 : d & msk(a);
  endtask

  task automatic rdc(input logic [12:0] a);
    host.xfer(1'b1, a, 8'h00, 24, q);
    chk(q, m[a], "register read");
    chk(sdo_oe, 1'b0, "data line released");
  endtask

  // Settings seen at the ports against the register model
  task automatic ports();
    chk(qctl, {m[13'h120][4:3], m[13'h120][1:0]}, "clock control");
    chk(trim, m[13'h121][1:0], "trim");
    chk(trim_s, 2'h3, "slow variant trim");
    chk(g0, {m[13'h130][5:4], m[13'h130][1:0]}, "gain 0");
    chk(g1, {m[13'h138][5:4], m[13'h138][1:0]}, "gain 1");
    chk(st0, {m[13'h132][1:0], m[13'h131]}, "step 0");
    chk(st1, {m[13'h13A][1:0], m[13'h139]}, "step 1");
  endtask

  // Boundary samples first, since they saturate at every nonzero gain code
  task automatic dsp(input int k);
    int v;
    logic [1:0] s [4];
    s = '{m[13'h130][5:4], m[13'h130][1:0], m[13'h138][5:4], m[13'h138][1:0]};
    @(negedge clk);
    foreach (din[i]) din[i] = k < 2 ? {k[0], {15{~k[0]}}} : 16'(rnd());
    @(negedge clk);
    foreach (din[i]) begin
      v = int'(din[i]) <<< s[i];
      v = v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
      chk(dout[i], 16'(v), "stage sample");
    end
  endtask

  // One tick every third cycle, counting output toggles
  task automatic run_ticks(input int n);
    logic qs;
    qs = qout;
    tog = 0;
    for (int i = 0; i < 3 * n; i++) begin
      @(negedge clk);
      tick = (i % 3 == 0);
      tog += (qout !== qs);
      qs = qout;
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    #8ms;
    mismatches++;
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    tick = 1'b0;
    foreach (din[i]) din[i] = 16'h0000;
    foreach (regs[i]) m[regs[i]] = 8'h00;
    m[13'h120] = 8'h11;
    m[13'h12A] = 8'h05;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    foreach (regs[i]) rdc(regs[i]);
    ports();
    $display("reset values done");
    foreach (regs[i]) begin
      wr(regs[i], 8'(rnd()));
      rdc(regs[i]);
    end
    host.xfer(1'b0, 13'h131, 8'(rnd()), 20, q);
    rdc(13'h131);
    for (int c = 0; c < 4; c++) begin
      wr(13'h121, 8'(c));
      wr(13'h130, 8'(c * 16 + 3 - c));
      wr(13'h138, 8'((3 - c) * 16 + c));
      ports();
      for (int k = 0; k < 4; k++) dsp(k);
    end
    $display("register and gain tests done");
    for (int e = 1; e >= 0; e--) begin
      wr(13'h120, {3'h0, e[0], 4'h2});
      p0 = ph0;
      p1 = ph1;
      run_ticks(8);
      chk(tog, e ? 4 : 0, "quarter clock toggles");
      chk(ph0, 10'(p0 + 8 * {m[13'h132][1:0], m[13'h131]}), "phase 0");
      chk(ph1, 10'(p1 + 8 * {m[13'h13A][1:0], m[13'h139]}), "phase 1");
    end
    chk(qout, 1'b0, "quarter clock idle");
    $display("clock and phase tests done");
    give_verdict();
  end
endmodule
